// ---- acs_pkg.sv ----
// Shared constants and types for the converter serial link and sequencing
package acs_pkg;
   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLK_MHZ = 250;
   localparam int RESET_WAIT_US = 200;
   localparam int RESET_WAIT_CYC = RESET_WAIT_US * CLK_MHZ;
   localparam int RESTART_LOW_CYC = 4;
   localparam int SETTLE_CONV = 4;
   localparam int HOST_GAP_CYC = 16;
   localparam int RESET_ONES = 40;
   // ----------------------------------------
   // Word sizes
   // ----------------------------------------
   localparam int CMD_BITS = 8;
   localparam int DATA_BITS = 24;
   localparam int STATUS_BITS = 8;
   localparam int MODE_BITS = 24;
   localparam int WORD_BITS = DATA_BITS + STATUS_BITS;
   // ----------------------------------------
   // Communications byte
   // ----------------------------------------
   localparam int COMM_WEN_BIT = 7;
   localparam int COMM_RW_BIT = 6;
   localparam int COMM_RS_MSB = 5;
   localparam int COMM_RS_LSB = 3;
   localparam int COMM_CREAD_BIT = 2;
   localparam logic [2:0] ADDR_STATUS = 3'h0;
   localparam logic [2:0] ADDR_MODE = 3'h1;
   localparam logic [2:0] ADDR_DATA = 3'h3;
   localparam logic [7:0] CMD_ENTER_CREAD = 8'h5c;
   localparam logic [7:0] CMD_EXIT_CREAD = 8'h58;
   localparam logic [7:0] CMD_READ_DATA = 8'h58;
   localparam logic [7:0] CMD_READ_STATUS = 8'h40;
   localparam logic [7:0] CMD_WRITE_MODE = 8'h08;
   // ----------------------------------------
   // Mode and status fields
   // ----------------------------------------
   localparam logic [MODE_BITS-1:0] MODE_RST = 24'h000000;
   localparam int MODE_APPEND_BIT = 20;
   localparam int MODE_PARITY_BIT = 13;
   localparam int STAT_PARITY_BIT = 4;
   // ----------------------------------------
   // Host operations
   // ----------------------------------------
   typedef enum logic [2:0] {
      OP_WRITE_MODE = 3'h0,
      OP_READ_DATA = 3'h1,
      OP_READ_STATUS = 3'h2,
      OP_ENTER_CREAD = 3'h3,
      OP_EXIT_CREAD = 3'h4,
      OP_RESET = 3'h5,
      OP_RESTART = 3'h6
   } acs_op_t;

   // Odd count of ones in a result word
   function automatic logic acs_odd(input logic [DATA_BITS-1:0] d);
      return ^d;
   endfunction
endpackage

// ---- acs_link_if.sv ----
// Serial link between the converter and its host controller
`timescale 1ns/1ps
interface acs_link_if;
   logic sclk;
   logic csN;
   logic din;
   logic doutRdyN;
   logic doutOe;
   logic restartN;

   modport dev (
      input sclk,
      input csN,
      input din,
      input restartN,
      output doutRdyN,
      output doutOe
   );
   modport host (
      output sclk,
      output csN,
      output din,
      output restartN,
      input doutRdyN,
      input doutOe
   );
endinterface

// ---- acs_pin_sync.sv ----
// Three-stage pin synchroniser; a change counts once stages two and three agree
`timescale 1ns/1ps
module acs_pin_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   // System
   input wire logic clk,
   input wire logic sys_rst,
   // Pins
   input wire logic [WIDTH-1:0] pinIn,
   output logic [WIDTH-1:0] level
);
   logic [WIDTH-1:0] s1_q;
   logic [WIDTH-1:0] s2_q;
   logic [WIDTH-1:0] s3_q;
   logic [WIDTH-1:0] lvl_q;

   if (WIDTH < 1) begin : g_bad
      $error("acs_pin_sync: WIDTH must be at least 1");
   end

   // Stage one feeds only stage two
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         s1_q <= RST_VAL;
         s2_q <= RST_VAL;
         s3_q <= RST_VAL;
         lvl_q <= RST_VAL;
      end else begin
         s1_q <= pinIn;
         s2_q <= s1_q;
         s3_q <= s2_q;
         lvl_q <= (s2_q & s3_q) | (lvl_q & (s2_q ^ s3_q));
      end
   end

   assign level = lvl_q;
endmodule

// ---- acs_device.sv ----
// Converter end: conversion sequencing, continuous read and serial delivery
`timescale 1ns/1ps
module acs_device import acs_pkg::*; #(
   parameter int CONV_CYC = 1024
) (
   // System
   input wire logic clk,
   input wire logic sys_rst,
   // Serial link
   acs_link_if.dev link,
   // Converter core
   input wire logic [DATA_BITS-1:0] sampleIn,
   input wire logic [3:0] sampleChan,
   // Status
   output logic convDone,
   output logic filterHeld,
   output logic creadActive,
   output logic appendStatus,
   output logic parityEnable
);
   localparam int SETTLE_CYC = SETTLE_CONV * CONV_CYC;
   localparam int CNT_W = $clog2(SETTLE_CYC + 1);
   localparam logic [5:0] ONES_MAX = 6'(RESET_ONES);

   if (CONV_CYC < 4) begin : g_bad
      $error("acs_device: CONV_CYC must be at least 4");
   end

   typedef enum logic [2:0] {
      S_CMD = 3'b001,
      S_WR = 3'b010,
      S_RD = 3'b100
   } acs_dstate_t;

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   logic sclkS, csNS, dinS, restartNS;
   acs_pin_sync #(.WIDTH(4), .RST_VAL(4'hd)) u_sync (
      .clk(clk),
      .sys_rst(sys_rst),
      .pinIn({link.sclk, link.csN, link.din, link.restartN}),
      .level({sclkS, csNS, dinS, restartNS})
   );

   logic sclkPrev_q, softRst_q, rst;
   logic sclkRise, sclkFall;
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         sclkPrev_q <= 1'b1;
      end else begin
         sclkPrev_q <= sclkS;
      end
   end
   assign sclkRise = sclkS & ~sclkPrev_q & ~csNS;
   assign sclkFall = ~sclkS & sclkPrev_q & ~csNS;
   assign rst = sys_rst | softRst_q;

   // ----------------------------------------
   // Forty-ones reset detector
   // ----------------------------------------
   logic [5:0] ones_q;
   always_ff @(posedge clk) begin
      if (rst) begin
         ones_q <= '0;
         softRst_q <= 1'b0;
      end else if (sclkRise) begin
         ones_q <= dinS ? ones_q + 6'h01 : 6'h00;
         softRst_q <= dinS && (ones_q == ONES_MAX - 6'h01);
      end
   end

   // ----------------------------------------
   // Conversion timer
   // ----------------------------------------
   logic hold_q;
   logic [CNT_W-1:0] cnt_q;
   logic convTick, preUpdate;
   // Release one clock after the synced rise, standing in for the next falling edge
   always_ff @(posedge clk) begin
      if (rst) begin
         hold_q <= 1'b0;
         cnt_q <= CNT_W'(SETTLE_CYC - 1);
      end else begin
         hold_q <= ~restartNS;
         if (hold_q) begin
            cnt_q <= CNT_W'(SETTLE_CYC - 1);
         end else if (cnt_q == '0) begin
            cnt_q <= CNT_W'(CONV_CYC - 1);
         end else begin
            cnt_q <= cnt_q - CNT_W'(1);
         end
      end
   end
   assign convTick = ~hold_q && (cnt_q == '0);
   assign preUpdate = ~hold_q && (cnt_q == CNT_W'(1));

   // ----------------------------------------
   // Serial engine state and data register
   // ----------------------------------------
   acs_dstate_t state_q;
   logic [7:0] cmdSh_q;
   logic [2:0] cmdCnt_q;
   logic [5:0] xfer_q;
   logic [MODE_BITS-1:0] wrSh_q, mode_q;
   logic [WORD_BITS-1:0] outSh_q;
   logic outValid_q, rdData_q, cread_q, rdyN_q;
   logic [DATA_BITS-1:0] data_q;
   logic [3:0] chan_q;
   logic [7:0] cmdByte;
   logic [2:0] cmdAddr;
   logic convStore, readDone;
   logic [5:0] dataLen;

   assign cmdByte = {cmdSh_q[6:0], dinS};
   assign cmdAddr = cmdByte[COMM_RS_MSB:COMM_RS_LSB];
   assign dataLen = mode_q[MODE_APPEND_BIT] ? 6'(WORD_BITS) : 6'(DATA_BITS);
   assign readDone = sclkRise && (state_q == S_RD) && outValid_q && (xfer_q == 6'h01);
   // Outside continuous read, a result is dropped when a data register read spans its completion
   assign convStore = convTick && !((state_q == S_RD) && rdData_q && !cread_q);

   // Status byte: ready, two zero flags, parity, channel
   function automatic logic [STATUS_BITS-1:0] mkStatus(input logic rdy, input logic [DATA_BITS-1:0] d,
                                                       input logic [3:0] ch);
      return {rdy, 2'b00, mode_q[MODE_PARITY_BIT] & acs_odd(d), ch};
   endfunction

   // Result goes out first, status trails it
   always_ff @(posedge clk) begin
      if (rst) begin
         data_q <= '0;
         chan_q <= '0;
      end else if (convStore) begin
         data_q <= sampleIn;
         chan_q <= sampleChan;
      end
   end

   // Ready flag: completion wins over both reasons to raise it
   always_ff @(posedge clk) begin
      if (rst) begin
         rdyN_q <= 1'b1;
      end else if (convStore) begin
         rdyN_q <= 1'b0;
      end else if (preUpdate) begin
         rdyN_q <= 1'b1;
      end else if (readDone && rdData_q) begin
         rdyN_q <= 1'b1;
      end
   end

   // Command decode, writes and shifting out
   always_ff @(posedge clk) begin
      if (rst) begin
         state_q <= S_CMD;
         cmdSh_q <= '0;
         cmdCnt_q <= '0;
         xfer_q <= '0;
         wrSh_q <= '0;
         mode_q <= MODE_RST;
         outSh_q <= '0;
         outValid_q <= 1'b0;
         rdData_q <= 1'b0;
         cread_q <= 1'b0;
      end else begin
         if (csNS) begin
            cmdCnt_q <= '0;
            outValid_q <= 1'b0;
            if (!cread_q) begin
               state_q <= S_CMD;
            end
         end else if (sclkRise) begin
            // Input stays watched during continuous read
            if (cread_q || state_q == S_CMD) begin
               cmdSh_q <= cmdByte;
               cmdCnt_q <= cmdCnt_q + 3'h1;
               if (cmdCnt_q == 3'h7) begin
                  if (cread_q) begin
                     if (cmdByte == CMD_EXIT_CREAD) begin
                        cread_q <= 1'b0;
                        state_q <= S_CMD;
                        outValid_q <= 1'b0;
                     end
                  end else if (!cmdByte[COMM_WEN_BIT]) begin
                     if (cmdByte[COMM_RW_BIT]) begin
                        if (cmdAddr == ADDR_DATA && cmdByte[COMM_CREAD_BIT]) begin
                           cread_q <= 1'b1;
                        end else begin
                           state_q <= S_RD;
                           outValid_q <= 1'b0;
                           rdData_q <= (cmdAddr == ADDR_DATA);
                           case (cmdAddr)
                              ADDR_DATA: begin
                                 outSh_q <= {data_q, mkStatus(rdyN_q, data_q, chan_q)};
                                 xfer_q <= dataLen;
                              end
                              ADDR_MODE: begin
                                 outSh_q <= {mode_q, 8'h00};
                                 xfer_q <= 6'(MODE_BITS);
                              end
                              default: begin
                                 outSh_q <= {mkStatus(rdyN_q, data_q, chan_q), 24'h000000};
                                 xfer_q <= 6'(STATUS_BITS);
                              end
                           endcase
                        end
                     end else if (cmdAddr == ADDR_MODE) begin
                        state_q <= S_WR;
                        xfer_q <= 6'(MODE_BITS);
                     end
                  end
               end
            end
            if (state_q == S_WR && !cread_q) begin
               wrSh_q <= {wrSh_q[MODE_BITS-2:0], dinS};
               xfer_q <= xfer_q - 6'h01;
               if (xfer_q == 6'h01) begin
                  mode_q <= {wrSh_q[MODE_BITS-2:0], dinS};
                  state_q <= S_CMD;
               end
            end else if (state_q == S_RD && outValid_q) begin
               xfer_q <= xfer_q - 6'h01;
               if (xfer_q == 6'h01) begin
                  state_q <= S_CMD;
                  outValid_q <= 1'b0;
               end
            end
         end else if (sclkFall && state_q == S_RD) begin
            // First falling edge presents the MSB, later ones advance
            if (outValid_q) begin
               outSh_q <= {outSh_q[WORD_BITS-2:0], 1'b0};
            end else begin
               outValid_q <= 1'b1;
            end
         end
         // In continuous read a new result replaces whatever was left in the shifter
         if (convStore && cread_q) begin
            outSh_q <= {sampleIn, mkStatus(1'b0, sampleIn, sampleChan)};
            xfer_q <= dataLen;
            state_q <= S_RD;
            outValid_q <= 1'b0;
            rdData_q <= 1'b1;
         end
      end
   end

   // ----------------------------------------
   // Pin and status outputs
   // ----------------------------------------
   logic dout_q, doutOe_q, convDone_q;
   always_ff @(posedge clk) begin
      if (rst) begin
         dout_q <= 1'b1;
         doutOe_q <= 1'b0;
         convDone_q <= 1'b0;
      end else begin
         dout_q <= (state_q == S_RD && outValid_q) ? outSh_q[WORD_BITS-1] : rdyN_q;
         doutOe_q <= ~csNS;
         convDone_q <= convStore;
      end
   end

   assign link.doutRdyN = dout_q;
   assign link.doutOe = doutOe_q;
   assign convDone = convDone_q;
   assign filterHeld = hold_q;
   assign creadActive = cread_q;
   assign appendStatus = mode_q[MODE_APPEND_BIT];
   assign parityEnable = mode_q[MODE_PARITY_BIT];
endmodule

// ---- acs_host.sv ----
// Host end: serial controller issuing commands and collecting results
`timescale 1ns/1ps
module acs_host import acs_pkg::*; #(
   parameter int SCLK_HALF = 16,
   parameter int RESET_WAIT = RESET_WAIT_CYC
) (
   // System
   input wire logic clk,
   input wire logic sys_rst,
   // Serial link
   acs_link_if.host link,
   // Requests
   input wire logic reqValid,
   output logic reqReady,
   input wire acs_op_t reqOp,
   input wire logic [MODE_BITS-1:0] reqData,
   // Answers
   output logic respValid,
   output logic [WORD_BITS-1:0] respData,
   output logic respBad,
   output logic creadOn
);
   localparam int WAIT_W = $clog2(RESET_WAIT + 1);
   localparam int HALF_W = $clog2(SCLK_HALF + 1);

   if (SCLK_HALF < 12 || RESET_WAIT < HOST_GAP_CYC) begin : g_bad
      $error("acs_host: SCLK_HALF or RESET_WAIT too small");
   end

   typedef enum logic [3:0] {
      H_WAIT = 4'b0001,
      H_IDLE = 4'b0010,
      H_SHIFT = 4'b0100,
      H_SYNC = 4'b1000
   } acs_hstate_t;

   // ----------------------------------------
   // Ready pin synchroniser
   // ----------------------------------------
   logic pinS;
   acs_pin_sync #(.WIDTH(1), .RST_VAL(1'b1)) u_sync (
      .clk(clk),
      .sys_rst(sys_rst),
      .pinIn(link.doutRdyN),
      .level(pinS)
   );

   // ----------------------------------------
   // Sequencer
   // ----------------------------------------
   acs_hstate_t state_q;
   logic [WAIT_W-1:0] wait_q;
   logic [HALF_W-1:0] half_q;
   logic sclk_q, din_q, csN_q, restartN_q, txFill_q;
   logic [39:0] txSh_q;
   logic [5:0] nBits_q;
   logic [WORD_BITS-1:0] rxSh_q, rxNext;
   logic isRead_q, isReset_q, append_q, parity_q, cread_q, respValid_q, respBad_q;
   logic [WORD_BITS-1:0] respData_q;
   logic autoRead;

   assign rxNext = {rxSh_q[WORD_BITS-2:0], pinS};
   // In continuous read only the exit byte may wait for ready low
   assign reqReady = (state_q == H_IDLE) &&
                     (!cread_q || (pinS ? reqOp != OP_EXIT_CREAD : reqOp == OP_EXIT_CREAD));
   assign autoRead = (state_q == H_IDLE) && cread_q && !pinS && !(reqValid && reqOp == OP_EXIT_CREAD);

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_q <= H_WAIT;
         wait_q <= WAIT_W'(RESET_WAIT - 1);
         half_q <= '0;
         sclk_q <= 1'b1;
         din_q <= 1'b0;
         csN_q <= 1'b1;
         restartN_q <= 1'b1;
         txFill_q <= 1'b0;
         txSh_q <= '0;
         nBits_q <= '0;
         rxSh_q <= '0;
         isRead_q <= 1'b0;
         isReset_q <= 1'b0;
         append_q <= 1'b0;
         parity_q <= 1'b0;
         cread_q <= 1'b0;
         respValid_q <= 1'b0;
         respBad_q <= 1'b0;
         respData_q <= '0;
      end else begin
         respValid_q <= 1'b0;
         case (state_q)
            H_WAIT: begin
               wait_q <= wait_q - WAIT_W'(1);
               if (wait_q == '0) begin
                  csN_q <= 1'b0;
                  state_q <= H_IDLE;
               end
            end
            H_IDLE: begin
               half_q <= '0;
               txFill_q <= 1'b0;
               isReset_q <= 1'b0;
               isRead_q <= 1'b0;
               if (autoRead) begin
                  txSh_q <= '0;
                  nBits_q <= append_q ? 6'(WORD_BITS) : 6'(DATA_BITS);
                  isRead_q <= 1'b1;
                  state_q <= H_SHIFT;
               end else if (reqValid && reqReady) begin
                  state_q <= H_SHIFT;
                  case (reqOp)
                     OP_WRITE_MODE: begin
                        txSh_q <= {CMD_WRITE_MODE, reqData, 8'h00};
                        nBits_q <= 6'(CMD_BITS + MODE_BITS);
                        append_q <= reqData[MODE_APPEND_BIT];
                        parity_q <= reqData[MODE_PARITY_BIT];
                     end
                     OP_READ_DATA: begin
                        txSh_q <= {CMD_READ_DATA, 32'h00000000};
                        nBits_q <= append_q ? 6'(CMD_BITS + WORD_BITS) : 6'(CMD_BITS + DATA_BITS);
                        isRead_q <= 1'b1;
                     end
                     OP_READ_STATUS: begin
                        txSh_q <= {CMD_READ_STATUS, 32'h00000000};
                        nBits_q <= 6'(CMD_BITS + STATUS_BITS);
                        isRead_q <= 1'b1;
                     end
                     OP_ENTER_CREAD: begin
                        txSh_q <= {CMD_ENTER_CREAD, 32'h00000000};
                        nBits_q <= 6'(CMD_BITS);
                        cread_q <= 1'b1;
                     end
                     OP_EXIT_CREAD: begin
                        txSh_q <= {CMD_EXIT_CREAD, 32'h00000000};
                        nBits_q <= 6'(CMD_BITS);
                        cread_q <= 1'b0;
                     end
                     OP_RESET: begin
                        txSh_q <= '1;
                        txFill_q <= 1'b1;
                        nBits_q <= 6'(RESET_ONES);
                        isReset_q <= 1'b1;
                        cread_q <= 1'b0;
                        append_q <= 1'b0;
                        parity_q <= 1'b0;
                     end
                     default: begin
                        // Restart: lowered on a clock edge, common to all devices
                        restartN_q <= 1'b0;
                        wait_q <= WAIT_W'(RESTART_LOW_CYC - 1);
                        state_q <= H_SYNC;
                     end
                  endcase
               end
            end
            H_SHIFT: begin
               half_q <= (half_q == HALF_W'(SCLK_HALF - 1)) ? '0 : half_q + HALF_W'(1);
               if (half_q == HALF_W'(SCLK_HALF - 1)) begin
                  if (sclk_q) begin
                     sclk_q <= 1'b0;
                     din_q <= txSh_q[39];
                     txSh_q <= {txSh_q[38:0], txFill_q};
                  end else begin
                     sclk_q <= 1'b1;
                     rxSh_q <= rxNext;
                     nBits_q <= nBits_q - 6'h01;
                     if (nBits_q == 6'h01) begin
                        respValid_q <= isRead_q;
                        respData_q <= rxNext;
                        // Even ones over data and parity bit
                        respBad_q <= isRead_q && parity_q && append_q &&
                                     (acs_odd(rxNext[WORD_BITS-1:STATUS_BITS]) ^ rxNext[STAT_PARITY_BIT]);
                        state_q <= H_SYNC;
                        wait_q <= isReset_q ? WAIT_W'(RESET_WAIT - 1) : WAIT_W'(HOST_GAP_CYC - 1);
                     end
                  end
               end
            end
            H_SYNC: begin
               // Also the gap that lets the ready pin settle after a read
               wait_q <= wait_q - WAIT_W'(1);
               // Data drops a clock after the last rise, so the far end still samples the final bit
               din_q <= 1'b0;
               if (wait_q == '0) begin
                  restartN_q <= 1'b1;
                  state_q <= H_IDLE;
               end
            end
            default: begin
               state_q <= H_IDLE;
            end
         endcase
      end
   end

   assign link.sclk = sclk_q;
   assign link.csN = csN_q;
   assign link.din = din_q;
   assign link.restartN = restartN_q;
   assign respValid = respValid_q;
   assign respData = respData_q;
   assign respBad = respBad_q;
   assign creadOn = cread_q;
endmodule

// ---- acs_link_sva.sv ----
// Assertions on the converter serial link and filter sequencing
`timescale 1ns/1ps
module acs_link_sva import acs_pkg::*; #(
   parameter int CONV_CYC = 1024
) (
   // System
   input wire logic clk,
   input wire logic sys_rst,
   // Link
   input wire logic sclk,
   input wire logic csN,
   input wire logic doutRdyN,
   input wire logic doutOe,
   input wire logic restartN,
   // Device status
   input wire logic convDone,
   input wire logic filterHeld
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   int sinceRel;
   // Clocks since the filter left hold; saturates so long runs never wrap
   always_ff @(posedge clk) begin
      if (sys_rst || filterHeld) sinceRel <= 0;
      else if (sinceRel < 32'h7fffffff) sinceRel <= sinceRel + 1;
   end
   chk_rdy_on_done: assert property (convDone && doutOe |=> !doutRdyN) else $error("ready high at result");
   chk_oe_follows_cs: assert property ($fell(csN) |-> ##[1:6] doutOe) else $error("pin not driven");
   chk_held_on_low: assert property ($fell(restartN) |-> ##[2:7] filterHeld) else $error("no hold");
   chk_held_while_low: assert property (!restartN [*4] |-> ##2 filterHeld [*4]) else $error("hold lost");
   chk_release_rise: assert property ($rose(restartN) |-> ##[2:7] !filterHeld) else $error("no release");
   chk_no_result_held: assert property (filterHeld |=> !convDone) else $error("result in hold");
   chk_settle_time: assert property (convDone |-> sinceRel > (SETTLE_CONV - 1) * CONV_CYC) else $error("early");
   chk_restart_width: assert property ($fell(restartN) |=> !restartN [*3]) else $error("short restart");
   chk_sclk_idle: assert property (csN |-> sclk) else $error("clock not idle high");
endmodule

// ---- test_adc_conversion_read_sync_control.sv ----
// Bench joining the converter end and the host end over the serial link
`timescale 1ns/1ps
module test_adc_conversion_read_sync_control import acs_pkg::*;;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic reqValid = 1'b0;
   acs_op_t reqOp = OP_READ_DATA;
   logic [MODE_BITS-1:0] reqData = '0;
   logic [DATA_BITS-1:0] sampleIn = 24'h5a3c70;
   logic [3:0] sampleChan = 4'h6;
   logic reqReady, respValid, respBad, creadOn, convDone, filterHeld, creadActive, appendStatus, parityEnable;
   logic [WORD_BITS-1:0] respData;
   int bad_count = 0;
   int n_compared = 0;
   acs_link_if link();
   acs_device #(.CONV_CYC(2048)) i_acs_device(.clk(clk), .sys_rst(sys_rst), .link(link), .sampleIn(sampleIn),
      .sampleChan(sampleChan), .convDone(convDone), .filterHeld(filterHeld), .creadActive(creadActive),
      .appendStatus(appendStatus), .parityEnable(parityEnable));
   acs_host #(.SCLK_HALF(12), .RESET_WAIT(200)) i_acs_host(.clk(clk), .sys_rst(sys_rst), .link(link),
      .reqValid(reqValid), .reqReady(reqReady), .reqOp(reqOp), .reqData(reqData), .respValid(respValid),
      .respData(respData), .respBad(respBad), .creadOn(creadOn));
   acs_link_sva #(.CONV_CYC(2048)) i_acs_link_sva(.clk(clk), .sys_rst(sys_rst), .sclk(link.sclk),
      .csN(link.csN), .doutRdyN(link.doutRdyN), .doutOe(link.doutOe), .restartN(link.restartN),
      .convDone(convDone), .filterHeld(filterHeld));
   // Clock
   initial begin
      forever #2 clk = ~clk;
   end
   task automatic final_report();
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Bounded wait for a level; values seen just after the edge are pre-edge
   task automatic await(ref logic s, input logic v, input int lim);
      for (int i = 0; i < lim; i++) begin
         @(posedge clk);
         if (s === v) return;
      end
      bad_count++;
      $display("MISMATCH at %0t: wait ran out", $time);
      final_report();
   endtask
   // One host request, held until the host takes it
   task automatic req(input acs_op_t op, input logic [MODE_BITS-1:0] d);
      @(posedge clk);
      reqOp <= op;
      reqData <= d;
      reqValid <= 1'b1;
      await(reqReady, 1'b1, 60000);
      reqValid <= 1'b0;
   endtask
   // Main sequence
   initial begin
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      await(convDone, 1'b1, 12000);
      // Pin register follows the flag one clock later
      @(posedge clk);
      check(32'(link.doutRdyN), 32'h0);
      // Both reads fit in one conversion period, so neither spans a completion
      for (int k = 0; k < 2; k++) begin
         req(OP_READ_DATA, '0);
         await(respValid, 1'b1, 3000);
         check(32'(respData[23:0]), 32'h5a3c70);
         // Ready rises a few clocks after the host's last sample
         repeat (8) @(posedge clk);
         check(32'(link.doutRdyN), 32'h1);
         sampleIn <= 24'h3c5a0f;
      end
      req(OP_WRITE_MODE, 24'h102000);
      await(appendStatus, 1'b1, 3000);
      check(32'(parityEnable), 32'h1);
      await(convDone, 1'b1, 3000);
      req(OP_READ_DATA, '0);
      await(respValid, 1'b1, 3000);
      check(respData, {sampleIn, 3'h0, ^sampleIn, sampleChan} & 32'hffffff7f);
      check(32'(respBad), 32'h0);
      req(OP_ENTER_CREAD, '0);
      await(creadActive, 1'b1, 3000);
      sampleIn <= 24'hc3e1f7;
      sampleChan <= 4'h9;
      await(respValid, 1'b1, 6000);
      await(respValid, 1'b1, 6000);
      check(respData & 32'hffffff7f, {24'hc3e1f7, 8'h19});
      repeat (8) @(posedge clk);
      check(32'(link.doutRdyN), 32'h1);
      req(OP_EXIT_CREAD, '0);
      await(creadActive, 1'b0, 3000);
      req(OP_RESTART, '0);
      await(filterHeld, 1'b1, 200);
      await(filterHeld, 1'b0, 200);
      await(convDone, 1'b1, 10000);
      req(OP_RESET, '0);
      await(appendStatus, 1'b0, 3000);
      check(32'(parityEnable), 32'h0);
      await(convDone, 1'b1, 12000);
      final_report();
   end
endmodule
